// ### pkg/sat_params.svh
`ifndef SAT_PARAMS_SVH
`define SAT_PARAMS_SVH

// ******************************************************
// special function register addresses
// ******************************************************
`define SAT_ADDR_CLOCK_PICK 8'h8e
`define SAT_ADDR_T3_CTL 8'h91
`define SAT_ADDR_T3_RLL 8'h92
`define SAT_ADDR_T3_RLH 8'h93
`define SAT_ADDR_T3_CNTL 8'h94
`define SAT_ADDR_T3_CNTH 8'h95
`define SAT_ADDR_T2_CTL 8'hc8
`define SAT_ADDR_T2_RLL 8'hca
`define SAT_ADDR_T2_RLH 8'hcb
`define SAT_ADDR_T2_CNTL 8'hcc
`define SAT_ADDR_T2_CNTH 8'hcd

// ******************************************************
// control register fields, same layout for both timers
// ******************************************************
`define SAT_BIT_FLAG_HIGH 7
`define SAT_BIT_FLAG_LOW 6
`define SAT_BIT_LOW_IRQ_EN 5
`define SAT_BIT_CAPTURE_EN 4
`define SAT_BIT_SPLIT 3
`define SAT_BIT_RUN 2
`define SAT_BIT_SRC_HI 1
`define SAT_BIT_SRC_LO 0

// ******************************************************
// clock pick register fields
// ******************************************************
`define SAT_CK_T2_LOW 4
`define SAT_CK_T2_HIGH 5
`define SAT_CK_T3_LOW 6
`define SAT_CK_T3_HIGH 7

// ******************************************************
// reset values and dividers
// ******************************************************
`define SAT_RESET_BYTE 8'h00
`define SAT_RESET_WORD 16'h0000
`define SAT_SYS_DIV 4'hc
`define SAT_OSC_DIV 4'h8

`endif

// ### pkg/sat_pkg.sv
package sat_pkg;

    typedef enum logic [3:0] {
        SAT_SEL_NONE,
        SAT_SEL_CLOCK_PICK,
        SAT_SEL_T2_CTL,
        SAT_SEL_T2_RLL,
        SAT_SEL_T2_RLH,
        SAT_SEL_T2_CNTL,
        SAT_SEL_T2_CNTH,
        SAT_SEL_T3_CTL,
        SAT_SEL_T3_RLL,
        SAT_SEL_T3_RLH,
        SAT_SEL_T3_CNTL,
        SAT_SEL_T3_CNTH
    } sat_sel_t;

    typedef struct packed {
        logic [15:0] count;
        logic [15:0] reload;
        logic set_high;
        logic set_low;
    } sat_step_t;

    typedef struct packed {
        logic [15:0] timer_two_count;
        logic [15:0] timer_two_reload;
        logic [7:0] timer_two_control;
        logic [15:0] third_count;
        logic [15:0] third_reload;
        logic [7:0] third_control;
        logic [7:0] clock_pick_register;
        logic [7:0] rdata;
    } sat_state_t;

    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
        logic pulse;
    } sat_sync_state_t;

    typedef struct packed {
        logic [3:0] count;
        logic tick;
    } sat_div_state_t;

endpackage

// ### verilog/sat_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser followed by a rising-edge pulse
module sat_edge_sync (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic async_in,
    output logic rise_out
);
    sat_pkg::sat_sync_state_t q, d;

    always_comb begin
        d = q;
        d.meta = async_in;
        d.sync = q.meta;
        d.prev = q.sync;
        // edge is taken from the second stage only, never from meta
        d.pulse = q.sync & ~q.prev;
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rise_out = q.pulse;
endmodule

`default_nettype wire

// ### verilog/sat_tick_div.sv
`timescale 1ns/1ps
`default_nettype none
`include "sat_params.svh"

// counts input events and emits one registered tick per DIV events
module sat_tick_div #(
    parameter logic [3:0] DIV = `SAT_SYS_DIV
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic event_in,
    output logic tick_out
);
    sat_pkg::sat_div_state_t q, d;

    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (event_in) begin
            if (q.count == DIV - 4'h1) begin
                d.count = 4'h0;
                d.tick = 1'b1;
            end else begin
                d.count = q.count + 4'h1;
            end
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick_out = q.tick;
endmodule

`default_nettype wire

// ### verilog/sat_timer_pair.sv
// Function
// [R01] timer two split bit: one picks two 8-bit reload counters, zero one 16-bit
// [R02] timer two run bit gates counting; in split mode only the high byte
// [R03] timer two source field picks alternate clock and capture trigger per table
// [R04] in split mode both bytes share the alternate clock; per-byte picks choose
// [R05] foreign sources are synchronised and act as enables on the system clock
// [R06] timer two reload low and high bytes are read/write at 0xca and 0xcb
// [R07] timer two count bytes at 0xcc and 0xcd form the count or two counters
// [R08] timer three is a 16-bit counter of two software-visible bytes
// [R09] timer three split bit at control bit 3 clear gives 16-bit auto-reload
// [R10] timer three counts system clock, clock/12, oscillator/8 or comparator one
// [R11] timer three 16-bit rollover loads reload value and sets high flag bit 7
// [R12] timer three enabled interrupt requests on every 16-bit overflow
// [R13] with low interrupt enable bit 5 set, low byte wraps also request
// [R14] timer three capture measures oscillator or comparator one period
// [R15] capture copies count into reload registers and sets high flag
// [R16] low flag is set on every low byte wrap in any mode
// [R17] hardware never clears flags; software clears them and checks both
// [R18] split bytes reload from own reload byte; timer two overflow like timer three
// [R19] register writes act next edge and beat a count in the same cycle
`timescale 1ns/1ps
`default_nettype none
`include "sat_params.svh"

module sat_timer_pair (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic [7:0] sfr_rdata_out,
    input wire logic rtc_osc_in,
    input wire logic ext_osc_in,
    input wire logic comp0_in,
    input wire logic comp1_in,
    input wire logic timer_two_irq_enable_in,
    input wire logic third_irq_enable_in,
    output logic timer_two_irq_out,
    output logic third_irq_out
);
    // ******************************************************
    // decode helpers
    // ******************************************************
    function automatic sat_pkg::sat_sel_t addr_sel(input logic [7:0] addr);
        sat_pkg::sat_sel_t s;
        s = sat_pkg::SAT_SEL_NONE;
        unique case (addr)
            `SAT_ADDR_CLOCK_PICK: s = sat_pkg::SAT_SEL_CLOCK_PICK;
            `SAT_ADDR_T2_CTL: s = sat_pkg::SAT_SEL_T2_CTL;
            `SAT_ADDR_T2_RLL: s = sat_pkg::SAT_SEL_T2_RLL;
            `SAT_ADDR_T2_RLH: s = sat_pkg::SAT_SEL_T2_RLH;
            `SAT_ADDR_T2_CNTL: s = sat_pkg::SAT_SEL_T2_CNTL;
            `SAT_ADDR_T2_CNTH: s = sat_pkg::SAT_SEL_T2_CNTH;
            `SAT_ADDR_T3_CTL: s = sat_pkg::SAT_SEL_T3_CTL;
            `SAT_ADDR_T3_RLL: s = sat_pkg::SAT_SEL_T3_RLL;
            `SAT_ADDR_T3_RLH: s = sat_pkg::SAT_SEL_T3_RLH;
            `SAT_ADDR_T3_CNTL: s = sat_pkg::SAT_SEL_T3_CNTL;
            `SAT_ADDR_T3_CNTH: s = sat_pkg::SAT_SEL_T3_CNTH;
            default: s = sat_pkg::SAT_SEL_NONE;
        endcase
        return s;
    endfunction

    // srcs[0..3] are the candidates for select codes 00..11
    function automatic logic pick4(input logic [1:0] sel, input logic [3:0] srcs);
        return srcs[sel];
    endfunction

    // one counting step of either timer; writes are applied afterwards
    function automatic sat_pkg::sat_step_t timer_step(
        input logic [15:0] count,
        input logic [15:0] reload,
        input logic [7:0] ctl,
        input logic tick_lo,
        input logic tick_hi,
        input logic capture
    );
        sat_pkg::sat_step_t s;
        s.count = count;
        s.reload = reload;
        s.set_high = 1'b0;
        s.set_low = 1'b0;
        if (ctl[`SAT_BIT_SPLIT]) begin // R01
            // low byte ignores the run bit in split mode
            if (tick_lo) begin // R02
                if (count[7:0] == 8'hff) begin
                    s.count[7:0] = reload[7:0]; // R18
                    s.set_low = 1'b1; // R16
                end else begin
                    s.count[7:0] = count[7:0] + 8'h01;
                end
            end
            if (ctl[`SAT_BIT_RUN] && tick_hi) begin // R02
                if (count[15:8] == 8'hff) begin
                    s.count[15:8] = reload[15:8]; // R18
                    s.set_high = 1'b1;
                end else begin
                    s.count[15:8] = count[15:8] + 8'h01;
                end
            end
        end else if (ctl[`SAT_BIT_RUN] && tick_lo) begin // R09
            if (count == 16'hffff) begin
                s.count = reload; // R11
                s.set_high = 1'b1; // R11
                s.set_low = 1'b1; // R16
            end else begin
                s.count = count + 16'h0001;
                s.set_low = (count[7:0] == 8'hff); // R16
            end
        end
        // capture is meant for 16-bit mode but is not blocked in split mode
        if (ctl[`SAT_BIT_CAPTURE_EN] && capture) begin // R14
            s.reload = count; // R15
            s.set_high = 1'b1; // R15
        end
        return s;
    endfunction

    // ******************************************************
    // clock sources
    // ******************************************************
    logic [3:0] pin_async;
    logic [3:0] pin_rise;
    logic sys_div_tick;
    logic rtc_div_tick;
    logic ext_div_tick;

    assign pin_async = {comp1_in, comp0_in, ext_osc_in, rtc_osc_in};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            sat_edge_sync u_sync ( // R05
                .clock_in(clock_in),
                .rst_in(rst_in),
                .async_in(pin_async[gi]),
                .rise_out(pin_rise[gi])
            );
        end
    endgenerate

    sat_tick_div #(.DIV(`SAT_SYS_DIV)) u_sys_div (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .event_in(1'b1),
        .tick_out(sys_div_tick)
    );

    sat_tick_div #(.DIV(`SAT_OSC_DIV)) u_rtc_div (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .event_in(pin_rise[0]),
        .tick_out(rtc_div_tick)
    );

    sat_tick_div #(.DIV(`SAT_OSC_DIV)) u_ext_div (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .event_in(pin_rise[1]),
        .tick_out(ext_div_tick)
    );

    // ******************************************************
    // state
    // ******************************************************
    sat_pkg::sat_state_t q, d;
    sat_pkg::sat_sel_t sel;
    sat_pkg::sat_step_t step_two, step_three;
    logic [1:0] src_two, src_three;
    logic alt_two, alt_three, trig_two, trig_three;
    logic tick_two_lo, tick_two_hi, tick_three_lo, tick_three_hi;

    assign sel = addr_sel(sfr_addr_in);
    assign src_two = q.timer_two_control[`SAT_BIT_SRC_HI:`SAT_BIT_SRC_LO];
    assign src_three = q.third_control[`SAT_BIT_SRC_HI:`SAT_BIT_SRC_LO];

    // one alternate clock feeds both bytes of a timer
    assign alt_two = pick4(src_two, {rtc_div_tick, sys_div_tick, pin_rise[2], sys_div_tick}); // R03 R04
    assign trig_two = src_two[1] ? pin_rise[2] : rtc_div_tick; // R03
    assign alt_three = pick4(src_three, {pin_rise[3], sys_div_tick, ext_div_tick, sys_div_tick}); // R10
    assign trig_three = src_three[1] ? ext_div_tick : pin_rise[3]; // R14

    // a set pick bit counts every system clock
    assign tick_two_lo = q.clock_pick_register[`SAT_CK_T2_LOW] | alt_two; // R04
    assign tick_two_hi = q.clock_pick_register[`SAT_CK_T2_HIGH] | alt_two; // R04
    assign tick_three_lo = q.clock_pick_register[`SAT_CK_T3_LOW] | alt_three; // R10
    assign tick_three_hi = q.clock_pick_register[`SAT_CK_T3_HIGH] | alt_three;

    assign step_two = timer_step(q.timer_two_count, q.timer_two_reload, q.timer_two_control,
                                 tick_two_lo, tick_two_hi, trig_two); // R18
    assign step_three = timer_step(q.third_count, q.third_reload, q.third_control,
                                   tick_three_lo, tick_three_hi, trig_three); // R08

    always_comb begin
        d = q;
        d.timer_two_count = step_two.count;
        d.timer_two_reload = step_two.reload;
        d.third_count = step_three.count;
        d.third_reload = step_three.reload;
        if (sfr_wr_in) begin // R19
            unique case (sel)
                sat_pkg::SAT_SEL_CLOCK_PICK: d.clock_pick_register = sfr_wdata_in;
                sat_pkg::SAT_SEL_T2_CTL: d.timer_two_control = sfr_wdata_in;
                sat_pkg::SAT_SEL_T2_RLL: d.timer_two_reload[7:0] = sfr_wdata_in; // R06
                sat_pkg::SAT_SEL_T2_RLH: d.timer_two_reload[15:8] = sfr_wdata_in; // R06
                sat_pkg::SAT_SEL_T2_CNTL: d.timer_two_count[7:0] = sfr_wdata_in; // R07
                sat_pkg::SAT_SEL_T2_CNTH: d.timer_two_count[15:8] = sfr_wdata_in; // R07
                sat_pkg::SAT_SEL_T3_CTL: d.third_control = sfr_wdata_in;
                sat_pkg::SAT_SEL_T3_RLL: d.third_reload[7:0] = sfr_wdata_in;
                sat_pkg::SAT_SEL_T3_RLH: d.third_reload[15:8] = sfr_wdata_in;
                sat_pkg::SAT_SEL_T3_CNTL: d.third_count[7:0] = sfr_wdata_in; // R08
                sat_pkg::SAT_SEL_T3_CNTH: d.third_count[15:8] = sfr_wdata_in; // R08
                sat_pkg::SAT_SEL_NONE: d.rdata = q.rdata;
            endcase
        end
        // hardware only sets flags; a set in the clearing cycle wins
        d.timer_two_control[`SAT_BIT_FLAG_HIGH] = d.timer_two_control[`SAT_BIT_FLAG_HIGH] | step_two.set_high; // R17
        d.timer_two_control[`SAT_BIT_FLAG_LOW] = d.timer_two_control[`SAT_BIT_FLAG_LOW] | step_two.set_low; // R17
        d.third_control[`SAT_BIT_FLAG_HIGH] = d.third_control[`SAT_BIT_FLAG_HIGH] | step_three.set_high; // R11
        d.third_control[`SAT_BIT_FLAG_LOW] = d.third_control[`SAT_BIT_FLAG_LOW] | step_three.set_low; // R16
        if (sfr_rd_in) begin
            unique case (sel)
                sat_pkg::SAT_SEL_CLOCK_PICK: d.rdata = q.clock_pick_register;
                sat_pkg::SAT_SEL_T2_CTL: d.rdata = q.timer_two_control;
                sat_pkg::SAT_SEL_T2_RLL: d.rdata = q.timer_two_reload[7:0];
                sat_pkg::SAT_SEL_T2_RLH: d.rdata = q.timer_two_reload[15:8];
                sat_pkg::SAT_SEL_T2_CNTL: d.rdata = q.timer_two_count[7:0];
                sat_pkg::SAT_SEL_T2_CNTH: d.rdata = q.timer_two_count[15:8];
                sat_pkg::SAT_SEL_T3_CTL: d.rdata = q.third_control;
                sat_pkg::SAT_SEL_T3_RLL: d.rdata = q.third_reload[7:0];
                sat_pkg::SAT_SEL_T3_RLH: d.rdata = q.third_reload[15:8];
                sat_pkg::SAT_SEL_T3_CNTL: d.rdata = q.third_count[7:0];
                sat_pkg::SAT_SEL_T3_CNTH: d.rdata = q.third_count[15:8];
                sat_pkg::SAT_SEL_NONE: d.rdata = `SAT_RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ******************************************************
    // outputs
    // ******************************************************
    assign sfr_rdata_out = q.rdata;
    assign timer_two_irq_out = timer_two_irq_enable_in & (q.timer_two_control[`SAT_BIT_FLAG_HIGH] |
        (q.timer_two_control[`SAT_BIT_FLAG_LOW] & q.timer_two_control[`SAT_BIT_LOW_IRQ_EN]));
    assign third_irq_out = third_irq_enable_in & (q.third_control[`SAT_BIT_FLAG_HIGH] | // R12
        (q.third_control[`SAT_BIT_FLAG_LOW] & q.third_control[`SAT_BIT_LOW_IRQ_EN])); // R13

    // ******************************************************
    // assertions
    // ******************************************************
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);

    logic split_two, run_two, split_three, run_three;
    assign split_two = q.timer_two_control[`SAT_BIT_SPLIT];
    assign run_two = q.timer_two_control[`SAT_BIT_RUN];
    assign split_three = q.third_control[`SAT_BIT_SPLIT];
    assign run_three = q.third_control[`SAT_BIT_RUN];

    sequence s_three_wrap;
        !sfr_wr_in && !split_three && run_three && tick_three_lo && q.third_count == 16'hffff;
    endsequence

    sequence s_three_low_wrap;
        !sfr_wr_in && !split_three && run_three && tick_three_lo && q.third_count[7:0] == 8'hff;
    endsequence

    a_two_split_low: assert property ( // R01
        !sfr_wr_in && split_two && tick_two_lo && q.timer_two_count[7:0] == 8'hff
        |=> q.timer_two_count[7:0] == $past(q.timer_two_reload[7:0]) && q.timer_two_control[6])
        else $error("timer two split low byte did not reload");

    a_two_run_gate: assert property ( // R02
        !sfr_wr_in && split_two && !run_two |=> $stable(q.timer_two_count[15:8]))
        else $error("timer two high byte counted while stopped");

    a_two_src_pick: assert property ( // R03
        !sfr_wr_in && !split_two && run_two && src_two == 2'b01 && !q.clock_pick_register[4]
        && !pin_rise[2] |=> $stable(q.timer_two_count))
        else $error("timer two counted without a comparator edge");

    a_two_tick_only: assert property ( // R05
        !sfr_wr_in && !tick_two_lo && !tick_two_hi |=> $stable(q.timer_two_count))
        else $error("timer two counted without a synchronised tick");

    a_reload_write: assert property ( // R06
        sfr_wr_in && sfr_addr_in == 8'hca |=> q.timer_two_reload[7:0] == $past(sfr_wdata_in))
        else $error("reload low write lost");

    a_count_write_wins: assert property ( // R19
        sfr_wr_in && sfr_addr_in == 8'hcd |=> q.timer_two_count[15:8] == $past(sfr_wdata_in))
        else $error("count write lost against increment");

    a_three_wrap_load: assert property ( // R11
        s_three_wrap |=> q.third_count == $past(q.third_reload) && q.third_control[7])
        else $error("timer three overflow did not reload");

    a_three_wrap_irq: assert property ( // R12
        s_three_wrap ##0 third_irq_enable_in ##1 third_irq_enable_in |-> third_irq_out)
        else $error("timer three overflow gave no request");

    a_three_low_irq: assert property ( // R13
        s_three_low_wrap ##0 q.third_control[5] ##1 third_irq_enable_in |-> third_irq_out)
        else $error("timer three low wrap gave no request");

    a_three_capture: assert property ( // R15
        !sfr_wr_in && q.third_control[4] && trig_three
        |=> q.third_reload == $past(q.third_count) && q.third_control[7])
        else $error("timer three capture failed");

    a_two_low_flag: assert property ( // R16
        !sfr_wr_in && !split_two && run_two && tick_two_lo && q.timer_two_count[7:0] == 8'hff
        |=> q.timer_two_control[6])
        else $error("timer two low flag not set");

    a_flags_sticky: assert property ( // R17
        !(sfr_wr_in && sfr_addr_in == 8'h91) && q.third_control[7] |=> q.third_control[7])
        else $error("timer three high flag cleared by hardware");

    a_three_split_high: assert property ( // R18
        !sfr_wr_in && split_three && run_three && tick_three_hi && q.third_count[15:8] == 8'hff
        |=> q.third_count[15:8] == $past(q.third_reload[15:8]) && q.third_control[7])
        else $error("timer three split high byte did not reload");

endmodule

`default_nettype wire

// ### tb/split_autoreload_timer_pair_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "sat_params.svh"

module split_autoreload_timer_pair_bench;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic [3:0] pins = 4'h0;
    logic [1:0] irq_en = 2'b00;
    logic [1:0] irq;
    logic [31:0] seed = 32'h4730b8da;
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;
    int n;
    logic [15:0] e;
    logic [7:0] a_ctl [2] = '{`SAT_ADDR_T2_CTL, `SAT_ADDR_T3_CTL};
    logic [7:0] a_rll [2] = '{`SAT_ADDR_T2_RLL, `SAT_ADDR_T3_RLL};
    logic [7:0] a_rlh [2] = '{`SAT_ADDR_T2_RLH, `SAT_ADDR_T3_RLH};
    logic [7:0] a_cl [2] = '{`SAT_ADDR_T2_CNTL, `SAT_ADDR_T3_CNTL};
    logic [7:0] a_ch [2] = '{`SAT_ADDR_T2_CNTH, `SAT_ADDR_T3_CNTH};

    always #5 clock_in = ~clock_in;

    // pins: 0 comparator 0, 1 comparator 1, 2 rtc oscillator, 3 external oscillator
    sat_timer_pair dut (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .sfr_addr_in(addr),
        .sfr_wr_in(wr),
        .sfr_rd_in(rd),
        .sfr_wdata_in(wdata),
        .sfr_rdata_out(rdata),
        .rtc_osc_in(pins[2]),
        .ext_osc_in(pins[3]),
        .comp0_in(pins[0]),
        .comp1_in(pins[1]),
        .timer_two_irq_enable_in(irq_en[0]),
        .third_irq_enable_in(irq_en[1]),
        .timer_two_irq_out(irq[0]),
        .third_irq_out(irq[1])
    );

    // ******************************
    // helpers
    // ******************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [15:0] nxt16(input logic [15:0] c, input logic [15:0] r);
        return (c == 16'hffff) ? r : c + 16'h0001;
    endfunction

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_in);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clock_in);
        wr = 1'b0;
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // read data is taken at the negedge after the strobe edge, when it has landed
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock_in);
        addr = a;
        rd = 1'b1;
        @(negedge clock_in);
        rd = 1'b0;
        cmp8(rdata, exp, $sformatf("reg %h", a));
    endtask

    task automatic pulse(input int t);
        @(negedge clock_in);
        pins[t] = 1'b1;
        repeat (4) @(negedge clock_in);
        pins[t] = 1'b0;
        repeat (4) @(negedge clock_in);
    endtask

    task automatic print_verdict;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // a full run takes about 700 cycles
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            print_verdict();
        end
    end

    // ******************************
    // main sequence
    // ******************************
    initial begin
        repeat (4) @(posedge clock_in);
        @(negedge clock_in);
        rst_in = 1'b0;
        for (int t = 0; t < 2; t++) begin
            chk_reg(a_ctl[t], 8'h00);
            chk_reg(a_rll[t], 8'h00);
            chk_reg(a_rlh[t], 8'h00);
            chk_reg(a_cl[t], 8'h00);
            chk_reg(a_ch[t], 8'h00);
        end
        wr_reg(8'h00, 8'hff);
        chk_reg(8'h00, 8'h00);
        $display("reset values done");
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            wr_reg(a_rll[i % 2], seed[7:0]);
            wr_reg(a_rlh[i % 2], seed[15:8]);
            wr_reg(a_cl[i % 2], seed[23:16]);
            wr_reg(a_ch[i % 2], seed[31:24]);
            chk_reg(a_rll[i % 2], seed[7:0]);
            chk_reg(a_rlh[i % 2], seed[15:8]);
            chk_reg(a_cl[i % 2], seed[23:16]);
            chk_reg(a_ch[i % 2], seed[31:24]);
        end
        $display("random access done");
        wr_reg(`SAT_ADDR_CLOCK_PICK, 8'h50);
        for (int t = 0; t < 2; t++) begin
            wr_reg(a_cl[t], 8'hff);
            wr_reg(a_ch[t], 8'hff);
            wr_reg(a_rll[t], 8'h34);
            wr_reg(a_rlh[t], 8'h12);
            irq_en[t] = 1'b1;
            // four counting edges: the rollover and one more during the read, one before and one with the stop write
            wr_reg(a_ctl[t], 8'h04);
            chk_reg(a_ctl[t], 8'hc4);
            wr_reg(a_ctl[t], 8'hc0);
            e = 16'hffff;
            repeat (4) e = nxt16(e, 16'h1234);
            chk_reg(a_cl[t], e[7:0]);
            chk_reg(a_ch[t], e[15:8]);
            chk_reg(a_ctl[t], 8'hc0);
            cmp8({7'h00, irq[t]}, 8'h01, "irq high flag");
            irq_en[t] = 1'b0;
            #1;
            cmp8({7'h00, irq[t]}, 8'h00, "irq masked");
            irq_en[t] = 1'b1;
            wr_reg(a_ctl[t], 8'h40);
            cmp8({7'h00, irq[t]}, 8'h00, "irq low only");
            wr_reg(a_ctl[t], 8'h60);
            cmp8({7'h00, irq[t]}, 8'h01, "irq low enabled");
            wr_reg(a_ctl[t], 8'h00);
            cmp8({7'h00, irq[t]}, 8'h00, "irq cleared");
        end
        $display("rollover done");
        wr_reg(`SAT_ADDR_CLOCK_PICK, 8'h30);
        wr_reg(a_rll[0], 8'hf0);
        wr_reg(a_rlh[0], 8'h77);
        wr_reg(a_cl[0], 8'hfe);
        wr_reg(a_ch[0], 8'hff);
        wr_reg(a_ctl[0], 8'h08);
        repeat (6) @(negedge clock_in);
        chk_reg(a_ch[0], 8'hff);
        chk_reg(a_ctl[0], 8'h48);
        wr_reg(a_ctl[0], 8'h0c);
        // stop in 16-bit mode so the split low byte no longer runs on
        wr_reg(a_ctl[0], 8'h00);
        chk_reg(a_ch[0], 8'h78);
        chk_reg(a_rll[0], 8'hf0);
        $display("split done");
        wr_reg(`SAT_ADDR_CLOCK_PICK, 8'h00);
        for (int t = 0; t < 2; t++) begin
            seed = xs(seed);
            n = 1 + seed[2:0] % 7;
            wr_reg(a_cl[t], 8'h00);
            wr_reg(a_ch[t], 8'h00);
            wr_reg(a_ctl[t], (t == 0) ? 8'h05 : 8'h07);
            repeat (n) pulse(t);
            wr_reg(a_ctl[t], 8'h00);
            chk_reg(a_cl[t], n[7:0]);
        end
        // oscillator sources divided by 8: sixteen edges give two counts
        for (int t = 0; t < 2; t++) begin
            wr_reg(a_cl[t], 8'h00);
            wr_reg(a_ctl[t], (t == 0) ? 8'h07 : 8'h05);
            repeat (16) pulse(2 + t);
            wr_reg(a_ctl[t], 8'h00);
            chk_reg(a_cl[t], 8'h02);
        end
        $display("pin clock done");
        for (int t = 0; t < 2; t++) begin
            wr_reg(a_cl[t], 8'hcd);
            wr_reg(a_ch[t], 8'hab);
            wr_reg(a_ctl[t], (t == 0) ? 8'h12 : 8'h10);
            pulse(t);
            chk_reg(a_rll[t], 8'hcd);
            chk_reg(a_rlh[t], 8'hab);
            chk_reg(a_ctl[t], (t == 0) ? 8'h92 : 8'h90);
        end
        $display("capture done");
        print_verdict();
    end
endmodule

`default_nettype wire
